/* design/rtc_pkg.sv */
// Package: register map, field layout and types of the wake-up timer
package rtc_pkg;
  localparam logic [7:0] TIMER_CONTROL_REG_OFS = 8'hD1;
  localparam logic [7:0] RELOAD_HIGH_OFS = 8'hD2;
  localparam logic [7:0] RELOAD_LOW_OFS = 8'hD3;
  localparam int ENABLE_POS = 0;
  localparam int IRQ_EN_POS = 1;
  localparam int SRC_LO_POS = 5;
  localparam int FLAG_POS = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h60;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [1:0] SRC_RESET = 2'h3;
  localparam logic [6:0] PRESCALE_ONES = 7'h7F;
  localparam logic [22:0] COUNT_ZERO = 23'h000000;

  typedef enum logic [1:0] {
    SRC_HF_XTAL = 2'h0,
    SRC_MF_XTAL = 2'h1,
    SRC_LF_XTAL = 2'h2,
    SRC_CPU = 2'h3
  } src_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic hf;
    logic mf;
    logic lf;
    logic cpu;
  } clk_ticks_t;
endpackage : rtc_pkg

/* design/rtc_wakeup_down_counter.sv */
// Wake-up down counter: 7-bit prescaler plus 16-bit reloadable counter
`timescale 1ns/1ps
// Operation
// - Counter is 23 bits, decrements once per selected tick while enabled.
// - Low 7 bits are prescaler, high 16 bits loadable counter.
// - High reload byte feeds bits 22:15, low byte feeds bits 14:7.
// - Enable low holds the whole counter at zero.
// - Enable written to one while it is zero loads reload bytes plus seven ones first.
// - A selected tick while at zero reloads the counter and sets flag bit 7.
// - Timer runs only while control bit 0 is one.
// - Crystal or external clock as CPU clock forces CPU clock source.
// - Source field bits 6:5 applies only on RC or watchdog CPU clock.
// - Codes 00/01/10 pick high/medium/low crystal, 11 the CPU clock.
// - Source field changes are ignored while timer already enabled.
// - Enable and source may be set in one write; clear enable first.
// - Interrupt needs local, shared and global enables all set.
// - Vector shared with watchdog; flag tells the cause.
// - Set flag is a wake-up source from power-down.
// - Only power-on reset returns timer and registers to defaults.
// - Flag stays set until software clears it by writing the bit.
// - Power-down bit stops counting and holds the count; enable bit keeps its value.
module rtc_wakeup_down_counter
  import rtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic cpu_on_rc_or_wdog_i,
  input wire logic tick_hf_i,
  input wire logic tick_mf_i,
  input wire logic tick_lf_i,
  input wire logic tick_cpu_i,
  input wire logic timer_power_down_bit_i,
  input wire logic shared_wdog_timer_irq_enable_i,
  input wire logic global_irq_enable_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic wake_o,
  output logic [22:0] count_o
);

  bus_req_t req;
  clk_ticks_t ticks;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign ticks = '{hf: tick_hf_i, mf: tick_mf_i, lf: tick_lf_i,
                   cpu: tick_cpu_i};

  logic enable_q, enable_d;
  logic irq_en_q, irq_en_d;
  logic flag_q, flag_d;
  logic [1:0] src_q, src_d;
  logic [7:0] reload_high_q, reload_low_q;
  logic [7:0] reload_high_d, reload_low_d;
  logic [22:0] count_q, count_d;
  logic [7:0] rdata_d;
  logic irq_d, wake_d;

  function automatic logic [22:0] reload_word(input logic [7:0] hi,
                                              input logic [7:0] lo);
    reload_word = {hi, lo, PRESCALE_ONES};
  endfunction : reload_word

  // One compare serves both the write and the read decoders
  function automatic logic at_addr(input logic [7:0] a,
                                   input logic [7:0] ofs);
    at_addr = (a == ofs);
  endfunction : at_addr

  wire sel_ctrl = at_addr(req.addr, TIMER_CONTROL_REG_OFS);
  wire sel_high = at_addr(req.addr, RELOAD_HIGH_OFS);
  wire sel_low = at_addr(req.addr, RELOAD_LOW_OFS);
  wire wr_ctrl = req.wr && sel_ctrl;
  wire wr_high = req.wr && sel_high;
  wire wr_low = req.wr && sel_low;

  // Rising edge of enable seen as a control write with enable newly set
  wire start = wr_ctrl && wdata_i[ENABLE_POS] && !enable_q;
  wire running = enable_q && !timer_power_down_bit_i;

  // Tick select: the CPU clock wins unless CPU runs on an RC or watchdog source
  src_sel_t src_eff;
  assign src_eff = cpu_on_rc_or_wdog_i ? src_sel_t'(src_q) : SRC_CPU;
  wire tick = (src_eff == SRC_HF_XTAL) ? ticks.hf :
              (src_eff == SRC_MF_XTAL) ? ticks.mf :
              (src_eff == SRC_LF_XTAL) ? ticks.lf : ticks.cpu;

  wire at_zero = (count_q == COUNT_ZERO);
  wire hit = running && tick && at_zero;
  wire pre_wrap = (count_q[6:0] == 7'h00);

  // Control register fields
  assign enable_d = wr_ctrl ? wdata_i[ENABLE_POS] : enable_q;
  assign irq_en_d = wr_ctrl ? wdata_i[IRQ_EN_POS] : irq_en_q;
  // Source accepted only while timer is off before this write
  assign src_d = (wr_ctrl && !enable_q) ? wdata_i[SRC_LO_POS +: 2]
                                        : src_q;
  // Set wins over a clearing write in the same cycle
  assign flag_d = hit ? 1'b1 :
                  (wr_ctrl && !wdata_i[FLAG_POS]) ? 1'b0 : flag_q;
  assign reload_high_d = wr_high ? wdata_i : reload_high_q;
  assign reload_low_d = wr_low ? wdata_i : reload_low_q;

  // Counter next value
  logic [22:0] dec_val;
  assign dec_val = pre_wrap ?
    {count_q[22:7] - 16'h0001, PRESCALE_ONES} :
    {count_q[22:7], count_q[6:0] - 7'h01};
  assign count_d = (!enable_d) ? COUNT_ZERO :
                   start ? reload_word(reload_high_q, reload_low_q) :
                   hit ? reload_word(reload_high_q, reload_low_q) :
                   (running && tick) ? dec_val : count_q;

  wire [7:0] ctrl_view = {flag_q, src_q, 3'h0, irq_en_q, enable_q};
  assign rdata_d = !req.rd ? 8'h00 :
                   sel_ctrl ? ctrl_view :
                   sel_high ? reload_high_q :
                   sel_low ? reload_low_q : 8'h00;

  assign irq_d = flag_d && irq_en_d && shared_wdog_timer_irq_enable_i
                 && global_irq_enable_i;
  assign wake_d = flag_d;

  // Synchronous reset stands for power-on reset only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enable_q <= CONTROL_RESET[ENABLE_POS];
    end else begin
      enable_q <= enable_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_en_q <= CONTROL_RESET[IRQ_EN_POS];
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_q <= CONTROL_RESET[FLAG_POS];
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      src_q <= SRC_RESET;
    end else begin
      src_q <= src_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reload_high_q <= RELOAD_RESET;
    end else begin
      reload_high_q <= reload_high_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reload_low_q <= RELOAD_RESET;
    end else begin
      reload_low_q <= reload_low_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_q <= COUNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= COUNT_ZERO;
    end else begin
      count_o <= count_d;
    end
  end

  sequence enable_write_s;
    wr_ctrl && wdata_i[ENABLE_POS] && !enable_q;
  endsequence

  sequence loaded_s;
    count_q == {$past(reload_high_q), $past(reload_low_q), PRESCALE_ONES};
  endsequence

  counter_load_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_write_s |=> loaded_s)
    else $error("Counter not loaded on enable");

  hold_zero_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !enable_q |-> count_q == COUNT_ZERO)
    else $error("Counter not zero while disabled");

  zero_reload_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (running && tick && at_zero && !(wr_ctrl && !wdata_i[ENABLE_POS]))
    |=> flag_q && count_q[6:0] == PRESCALE_ONES)
    else $error("No reload and flag at zero");

  flag_sticky_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    flag_q && !wr_ctrl |=> flag_q)
    else $error("Flag dropped without a write");

  src_locked_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_q |=> src_q == $past(src_q))
    else $error("Source changed while enabled");

  power_hold_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    timer_power_down_bit_i && enable_q && !wr_ctrl
    |=> count_q == $past(count_q))
    else $error("Counter moved while powered down");

  upper_step_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    running && tick && !at_zero && count_q[6:0] != 7'h00 && !wr_ctrl
    |=> count_q[22:7] == $past(count_q[22:7]))
    else $error("Upper counter moved without wrap");

  irq_gate_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    irq_o |-> flag_q && irq_en_q && $past(global_irq_enable_i)
      && $past(shared_wdog_timer_irq_enable_i))
    else $error("Interrupt without all enables");

  wake_follow_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wake_o == flag_q)
    else $error("Wake does not follow flag");

  stall_idle_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_q && !tick && !wr_ctrl |=> count_q == $past(count_q))
    else $error("Counter moved without a tick");

  sequence step_s;
    running && tick && !at_zero && !wr_ctrl;
  endsequence

  sequence clear_write_s;
    wr_ctrl && !wdata_i[FLAG_POS] && !hit;
  endsequence

  sequence src_write_s;
    wr_ctrl && !enable_q;
  endsequence

  count_step_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    step_s |=> count_q == $past(count_q) - 23'h000001)
    else $error("Counter did not step by one");

  prescale_wrap_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    running && tick && pre_wrap && !at_zero && !wr_ctrl
    |=> count_q[6:0] == PRESCALE_ONES)
    else $error("Prescaler did not wrap to ones");

  disable_clear_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_ctrl && !wdata_i[ENABLE_POS]
    |=> !enable_q && count_q == COUNT_ZERO)
    else $error("Counter not cleared by disable");

  reload_value_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    hit && enable_d |=> count_q[22:15] == $past(reload_high_q)
      && count_q[14:7] == $past(reload_low_q))
    else $error("Reload bytes in wrong positions");

  cpu_forced_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_q && !cpu_on_rc_or_wdog_i && !tick_cpu_i && !wr_ctrl
    |=> count_q == $past(count_q))
    else $error("Counter moved without a CPU tick");

  hf_pick_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_q && cpu_on_rc_or_wdog_i && src_q == SRC_HF_XTAL
      && !tick_hf_i && !wr_ctrl
    |=> count_q == $past(count_q))
    else $error("Source field not applied on RC clock");

  lf_pick_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    enable_q && cpu_on_rc_or_wdog_i && src_q == SRC_LF_XTAL
      && !tick_lf_i && !wr_ctrl
    |=> count_q == $past(count_q))
    else $error("Low crystal code counted another tick");

  src_take_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    src_write_s |=> src_q == $past(wdata_i[SRC_LO_POS +: 2]))
    else $error("Source not taken with enable write");

  irq_block_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !(shared_wdog_timer_irq_enable_i && global_irq_enable_i)
    |=> !irq_o)
    else $error("Interrupt with a shared enable low");

  irq_cause_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    irq_o |-> wake_o)
    else $error("Interrupt without the flag set");

  flag_read_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    req.rd && sel_ctrl |=> rdata_o[FLAG_POS] == $past(flag_q))
    else $error("Flag not visible to a read");

  flag_clear_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    clear_write_s |=> !flag_q)
    else $error("Flag not cleared by its write");

  power_flag_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    timer_power_down_bit_i && !flag_q |=> !flag_q)
    else $error("Flag set while powered down");

  reload_defer_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_high || wr_low) && enable_q && !tick
    |=> count_q == $past(count_q))
    else $error("Reload write moved the running count");

  wake_rise_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    hit |=> wake_o)
    else $error("No wake after the count ran out");

  reset_clear_a: assert property (
    @(posedge clk_i)
    srst_i |=> count_o == COUNT_ZERO && !irq_o && !wake_o
      && rdata_o == 8'h00)
    else $error("Outputs not cleared by reset");

endmodule : rtc_wakeup_down_counter

/* verification/rtc_wakeup_down_counter_bench.sv */
// Self-checking bench for the wake-up down counter
`timescale 1ns/1ps
module rtc_wakeup_down_counter_bench;
  import rtc_pkg::*;
  logic clk_i, srst_i, wr_i, rd_i, rc_i, pd_i, sh_i, gl_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [3:0] tk;
  logic irq_o, wake_o;
  logic [22:0] count_o, e;
  int err_count, tests_run;
  // Rows: CPU on RC, source code, counting tick mask {hf,mf,lf,cpu}
  logic [6:0] rows [8] = '{7'h48, 7'h54, 7'h62, 7'h71,
                           7'h01, 7'h11, 7'h21, 7'h31};

  rtc_wakeup_down_counter dut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .cpu_on_rc_or_wdog_i(rc_i),
    .tick_hf_i(tk[3]), .tick_mf_i(tk[2]), .tick_lf_i(tk[1]),
    .tick_cpu_i(tk[0]), .timer_power_down_bit_i(pd_i),
    .shared_wdog_timer_irq_enable_i(sh_i), .global_irq_enable_i(gl_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .wake_o(wake_o), .count_o(count_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [22:0] s, input logic [22:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", n, x, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i) wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data is valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_i) addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i) rd_i <= 1'b0;
    #1 chk("rdata", {15'h0, rdata_o}, {15'h0, x});
  endtask : rd

  task automatic tick(input logic [3:0] m);
    @(posedge clk_i) tk <= m;
    @(posedge clk_i) tk <= 4'h0;
    #1;
  endtask : tick

  initial begin
    {wr_i, rd_i, rc_i, pd_i, sh_i, gl_i, tk} = '0;
    {addr_i, wdata_i} = '0;
    err_count = 0;
    tests_run = 0;
    srst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(TIMER_CONTROL_REG_OFS, CONTROL_RESET);
    rd(RELOAD_HIGH_OFS, RELOAD_RESET);
    rd(RELOAD_LOW_OFS, RELOAD_RESET);
    rd(8'hD4, 8'h00);
    chk("count", count_o, COUNT_ZERO);
    wr(RELOAD_HIGH_OFS, 8'hA5);
    wr(RELOAD_LOW_OFS, 8'h3C);
    rd(RELOAD_HIGH_OFS, 8'hA5);
    wr(TIMER_CONTROL_REG_OFS, 8'h61);
    chk("count", count_o, {8'hA5, 8'h3C, PRESCALE_ONES});
    wr(RELOAD_HIGH_OFS, 8'h00);
    wr(RELOAD_LOW_OFS, 8'h01);
    tick(4'h1);
    chk("count", count_o, {8'hA5, 8'h3C, 7'h7E});
    wr(TIMER_CONTROL_REG_OFS, 8'h60);
    chk("count", count_o, COUNT_ZERO);
    tick(4'h1);
    chk("count", count_o, COUNT_ZERO);
    foreach (rows[r]) begin
      @(posedge clk_i) rc_i <= rows[r][6];
      wr(TIMER_CONTROL_REG_OFS, 8'h00);
      wr(TIMER_CONTROL_REG_OFS, {1'b0, rows[r][5:4], 5'h01});
      rd(TIMER_CONTROL_REG_OFS, {1'b0, rows[r][5:4], 5'h01});
      e = 23'h0000FF;
      chk("count", count_o, e);
      for (int i = 0; i < 4; i++) begin
        tick(4'h8 >> i);
        if (rows[r][3 - i]) e = e - 23'h000001;
        chk("count", count_o, e);
      end
    end
    wr(TIMER_CONTROL_REG_OFS, 8'h01);
    rd(TIMER_CONTROL_REG_OFS, 8'h61);
    chk("count", count_o, 23'h0000FE);
    @(posedge clk_i) pd_i <= 1'b1;
    tick(4'h1);
    chk("count", count_o, 23'h0000FE);
    @(posedge clk_i) pd_i <= 1'b0;
    repeat (127) tick(4'h1);
    chk("count", count_o, 23'h00007F);
    repeat (127) tick(4'h1);
    chk("count", count_o, COUNT_ZERO);
    tick(4'h1);
    repeat (2) @(posedge clk_i);
    #1 chk("count", count_o, 23'h0000FF);
    chk("wake", wake_o, 1'b1);
    chk("irq", irq_o, 1'b0);
    rd(TIMER_CONTROL_REG_OFS, 8'hE1);
    wr(TIMER_CONTROL_REG_OFS, 8'hE3);
    @(posedge clk_i) sh_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("irq", irq_o, 1'b0);
    @(posedge clk_i) gl_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("irq", irq_o, 1'b1);
    rd(TIMER_CONTROL_REG_OFS, 8'hE3);
    wr(TIMER_CONTROL_REG_OFS, 8'h63);
    repeat (2) @(posedge clk_i);
    #1 chk("wake", wake_o, 1'b0);
    chk("irq", irq_o, 1'b0);
    // Second reset in mid-run must clear count and restore the control register
    @(posedge clk_i) srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1 chk("count", count_o, COUNT_ZERO);
    rd(TIMER_CONTROL_REG_OFS, CONTROL_RESET);
    close_out();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule : rtc_wakeup_down_counter_bench
